// ---- rtl/sif_top.sv ----
// Behaviour
// - Separate interrupt filters for light and proximity.
// - Light filter uses first channel result only.
// - Light code zero: interrupt every light cycle.
// - Light codes one to three: that many.
// - Light codes four up: five per step.
// - Proximity code zero: interrupt every proximity cycle.
// - Proximity code N needs N consecutive results.
// - Wait multiplier bit stretches waits twelvefold.
// - Proximity cycle follows each light cycle.
// - Burst of programmed LED pulses at 62.5 kHz.
// - Bits 7:6 select LED drive current.
// - Proximity gain 00 (bits 3:2 pass to PROX_GAIN_SEL as written, not forced); light gain 1/8/16/120.
// - Below low or above high is out.
// - Wait counts 2.72 ms steps, two's complement.
// - Filtered interrupts need their enable bit.
`timescale 1ns/10ps
`default_nettype none

module sif_top #(
    parameter int WAIT_STEP_CYC = sif_pkg::SIF_WAIT_STEP_CYC
) (
    input wire logic REF_CLK, // System clock, 20 MHz.
    input wire logic RSTN, // Asynchronous reset, active low.
    input wire logic [7:0] REG_ADDR, // Register address.
    input wire logic REG_WR, // Write strobe, one cycle.
    input wire logic [7:0] REG_WDATA, // Write data.
    output logic [7:0] REG_RDATA, // Registered read data.
    input wire logic RUN, // Powered and light measurement enabled.
    input wire logic PROX_ENABLE, // Proximity function enabled.
    input wire logic WAIT_ENABLE, // Wait state enabled.
    input wire logic LIGHT_IRQ_ENABLE, // Light interrupt enable.
    input wire logic PROX_IRQ_ENABLE, // Proximity interrupt enable.
    input wire logic [7:0] WAIT_PERIOD_VALUE, // Wait steps, two's compl.
    input wire logic LIGHT_DONE, // Light integration complete.
    input wire logic [15:0] LIGHT_CH0, // First light channel result.
    input wire logic [15:0] LIGHT_LOW_THR, // Light low threshold.
    input wire logic [15:0] LIGHT_HIGH_THR, // Light high threshold.
    input wire logic PROX_DONE, // Proximity integration complete.
    input wire logic [15:0] PROX_DATA, // Proximity result.
    input wire logic [15:0] PROX_LOW_THR, // Proximity low threshold.
    input wire logic [15:0] PROX_HIGH_THR, // Proximity high threshold.
    output logic LIGHT_START, // One-cycle start of light cycle.
    output logic LED_PULSE, // LED pulse train.
    output logic WAITING, // Sequencer in wait state.
    output logic [1:0] LED_CURRENT_SEL, // LED drive current code.
    output logic [1:0] PROX_PHOTODIODE_SEL, // Proximity diode code.
    output logic [1:0] PROX_GAIN_SEL, // Proximity gain code.
    output logic [1:0] LIGHT_GAIN_SEL, // Light gain code.
    output logic LIGHT_IRQ, // One-cycle filtered light event.
    output logic PROX_IRQ // One-cycle filtered proximity event.
);
    import sif_pkg::*;

    localparam int WDW = $clog2(WAIT_STEP_CYC);
    localparam logic [WDW-1:0] WDIV_LAST = WDW'(WAIT_STEP_CYC - 1);

    typedef struct packed {
        sif_state_t st;
        logic [7:0] filter;
        logic wait_mult;
        logic [7:0] pulses;
        logic [7:0] afe;
        logic [7:0] rdata;
        logic light_start;
        logic pulse_start;
        logic [8:0] steps;
        logic [3:0] mult;
        logic [WDW-1:0] div;
    } sif_top_t;

    sif_top_t st_ff;
    sif_top_t nxt_st;
    sif_meas_t meas [2];
    logic [3:0] codes [2];
    logic irq_en [2];
    logic irq_evt [2];
    logic pulse_done;
    logic cycle_end;
    logic step_tick;

    // Channel 0 is light, channel 1 is proximity.
    always_comb begin
        meas[0].done = LIGHT_DONE && (st_ff.st == SIF_ST_LIGHT);
        meas[0].value = LIGHT_CH0;
        meas[0].low = LIGHT_LOW_THR;
        meas[0].high = LIGHT_HIGH_THR;
        meas[1].done = PROX_DONE && (st_ff.st == SIF_ST_PROX);
        meas[1].value = PROX_DATA;
        meas[1].low = PROX_LOW_THR;
        meas[1].high = PROX_HIGH_THR;
        codes[0] = st_ff.filter[SIF_LIGHT_FILT_LSB +: 4];
        codes[1] = st_ff.filter[SIF_PROX_FILT_LSB +: 4];
        irq_en[0] = LIGHT_IRQ_ENABLE;
        irq_en[1] = PROX_IRQ_ENABLE;
    end

    for (genvar g = 0; g < 2; g++) begin : g_filter
        sif_persist #(
            .IS_LIGHT(g == 0)
        ) u_persist (
            .clk(REF_CLK),
            .rst_n(RSTN),
            .meas(meas[g]),
            .code(codes[g]),
            .irq_enable(irq_en[g]),
            .irq(irq_evt[g])
        );
    end

    sif_pulse_gen u_pulse (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .start(st_ff.pulse_start),
        .count(st_ff.pulses),
        .led(LED_PULSE),
        .done(pulse_done)
    );

    assign step_tick = (st_ff.div == WDIV_LAST);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.light_start = 1'b0;
        nxt_st.pulse_start = 1'b0;
        cycle_end = 1'b0;

        if (REG_WR) begin
            case (REG_ADDR)
                SIF_OFS_FILTER: begin
                    nxt_st.filter = REG_WDATA;
                end
                SIF_OFS_WAITCFG: begin
                    // Only the multiplier bit is kept; reserved bits read 0.
                    nxt_st.wait_mult = REG_WDATA[SIF_WAIT_MULT_BIT];
                end
                SIF_OFS_PULSES: begin
                    nxt_st.pulses = REG_WDATA;
                end
                SIF_OFS_AFE: begin
                    nxt_st.afe = REG_WDATA;
                end
                default: begin
                end
            endcase
        end

        case (REG_ADDR)
            SIF_OFS_FILTER: nxt_st.rdata = st_ff.filter;
            SIF_OFS_WAITCFG: begin
                nxt_st.rdata = 8'h00;
                nxt_st.rdata[SIF_WAIT_MULT_BIT] = st_ff.wait_mult;
            end
            SIF_OFS_PULSES: nxt_st.rdata = st_ff.pulses;
            SIF_OFS_AFE: nxt_st.rdata = st_ff.afe;
            default: nxt_st.rdata = 8'h00;
        endcase

        case (st_ff.st)
            SIF_ST_IDLE: begin
                if (RUN) begin
                    nxt_st.st = SIF_ST_LIGHT;
                    nxt_st.light_start = 1'b1;
                end
            end
            SIF_ST_LIGHT: begin
                if (LIGHT_DONE) begin
                    if (PROX_ENABLE) begin
                        nxt_st.st = SIF_ST_PULSE;
                        nxt_st.pulse_start = 1'b1;
                    end else begin
                        cycle_end = 1'b1;
                    end
                end
            end
            SIF_ST_PULSE: begin
                if (pulse_done) begin
                    nxt_st.st = SIF_ST_PROX;
                end
            end
            SIF_ST_PROX: begin
                if (PROX_DONE) begin
                    cycle_end = 1'b1;
                end
            end
            SIF_ST_WAIT: begin
                // Steps of the base period; each step is repeated twelve
                // times when the multiplier is on.
                nxt_st.div = step_tick ? '0 : st_ff.div + 1'b1;
                if (step_tick) begin
                    if (st_ff.wait_mult &&
                        st_ff.mult != SIF_LONG_WAIT_FACTOR - 4'h1) begin
                        nxt_st.mult = st_ff.mult + 4'h1;
                    end else begin
                        nxt_st.mult = 4'h0;
                        nxt_st.steps = st_ff.steps - 9'h001;
                        if (st_ff.steps == 9'h001) begin
                            nxt_st.st = SIF_ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                nxt_st.st = SIF_ST_IDLE;
            end
        endcase

        if (cycle_end) begin
            nxt_st.div = '0;
            nxt_st.mult = 4'h0;
            // Value 0xff gives one step, 0x00 gives 256.
            nxt_st.steps = SIF_WAIT_WRAP - {1'b0, WAIT_PERIOD_VALUE};
            nxt_st.st = WAIT_ENABLE ? SIF_ST_WAIT : SIF_ST_IDLE;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff <= '0;
            st_ff.st <= SIF_ST_IDLE;
            st_ff.filter <= SIF_RST_FILTER;
            st_ff.wait_mult <= SIF_RST_WAIT_MULT;
            st_ff.pulses <= SIF_RST_PULSES;
            st_ff.afe <= SIF_RST_AFE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA = st_ff.rdata;
    assign LIGHT_START = st_ff.light_start;
    assign WAITING = (st_ff.st == SIF_ST_WAIT);
    assign LED_CURRENT_SEL = st_ff.afe[SIF_LED_CUR_LSB +: 2];
    assign PROX_PHOTODIODE_SEL = st_ff.afe[SIF_DIODE_LSB +: 2];
    assign PROX_GAIN_SEL = st_ff.afe[SIF_PROX_GAIN_LSB +: 2];
    assign LIGHT_GAIN_SEL = st_ff.afe[SIF_LIGHT_GAIN_LSB +: 2];
    assign LIGHT_IRQ = irq_evt[0];
    assign PROX_IRQ = irq_evt[1];

endmodule // sif_top

`default_nettype wire

// ---- rtl/sif_pkg.sv ----
package sif_pkg;

    // Register offsets on the device's byte-wide register port.
    localparam logic [7:0] SIF_OFS_FILTER = 8'h0c;
    localparam logic [7:0] SIF_OFS_WAITCFG = 8'h0d;
    localparam logic [7:0] SIF_OFS_PULSES = 8'h0e;
    localparam logic [7:0] SIF_OFS_AFE = 8'h0f;

    // Values after reset.
    localparam logic [7:0] SIF_RST_FILTER = 8'h00;
    localparam logic [7:0] SIF_RST_PULSES = 8'h00;
    localparam logic [7:0] SIF_RST_AFE = 8'h00;
    localparam logic SIF_RST_WAIT_MULT = 1'b0;

    // Field positions.
    localparam int SIF_LIGHT_FILT_LSB = 0;
    localparam int SIF_PROX_FILT_LSB = 4;
    localparam int SIF_WAIT_MULT_BIT = 1;
    localparam int SIF_LIGHT_GAIN_LSB = 0;
    localparam int SIF_PROX_GAIN_LSB = 2;
    localparam int SIF_DIODE_LSB = 4;
    localparam int SIF_LED_CUR_LSB = 6;

    // Timing.
    localparam int SIF_CLK_PERIOD_NS = 50;
    localparam int SIF_CLK_HZ = 20_000_000;
    localparam int SIF_PULSE_RATE_HZ = 62_500;
    localparam int SIF_PULSE_PERIOD_CYC = SIF_CLK_HZ / SIF_PULSE_RATE_HZ;
    localparam int SIF_PULSE_HIGH_CYC = SIF_PULSE_PERIOD_CYC / 2;
    localparam int SIF_WAIT_STEP_NS = 2_720_000;
    localparam int SIF_WAIT_STEP_CYC = SIF_WAIT_STEP_NS / SIF_CLK_PERIOD_NS;
    localparam logic [3:0] SIF_LONG_WAIT_FACTOR = 4'hc;
    localparam logic [8:0] SIF_WAIT_WRAP = 9'h100;

    // Persistence codes at or below this map one to one on the light path.
    localparam logic [3:0] SIF_LIGHT_DIRECT_MAX = 4'h3;
    localparam logic [5:0] SIF_LIGHT_STEP = 6'h05;
    localparam logic [5:0] SIF_LIGHT_OFFSET = 6'h0f;

    typedef struct packed {
        logic done;
        logic [15:0] value;
        logic [15:0] low;
        logic [15:0] high;
    } sif_meas_t;

    typedef enum logic [2:0] {
        SIF_ST_IDLE = 3'b000,
        SIF_ST_LIGHT = 3'b001,
        SIF_ST_PULSE = 3'b010,
        SIF_ST_PROX = 3'b011,
        SIF_ST_WAIT = 3'b100
    } sif_state_t;

endpackage

// ---- rtl/sif_persist.sv ----
`timescale 1ns/10ps
`default_nettype none

module sif_persist #(
    parameter bit IS_LIGHT = 1'b1
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire sif_pkg::sif_meas_t meas, // Completed result and window.
    input wire logic [3:0] code, // Persistence code of this channel.
    input wire logic irq_enable, // Lets the filtered event out.
    output logic irq // One-cycle filtered interrupt event.
);
    import sif_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic irq;
    } sif_persist_t;

    sif_persist_t st_ff;
    sif_persist_t nxt_st;
    logic [5:0] need;
    logic [5:0] code6;
    logic out_of_range;

    always_comb begin
        code6 = {2'b00, code};
        if (!IS_LIGHT || code <= SIF_LIGHT_DIRECT_MAX) begin
            need = code6;
        end else begin
            need = code6 * SIF_LIGHT_STEP - SIF_LIGHT_OFFSET;
        end
    end

    assign out_of_range = (meas.value < meas.low) ||
                          (meas.value > meas.high);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;
        if (meas.done) begin
            if (code == 4'h0) begin
                nxt_st.cnt = 6'h00;
                nxt_st.irq = irq_enable;
            end else if (!out_of_range) begin
                nxt_st.cnt = 6'h00;
            end else if (st_ff.cnt < need) begin
                // The count saturates so a long run raises one event only.
                nxt_st.cnt = st_ff.cnt + 6'h01;
                nxt_st.irq = irq_enable &&
                             (st_ff.cnt + 6'h01 == need);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq = st_ff.irq;

endmodule // sif_persist

`default_nettype wire

// ---- rtl/sif_pulse_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module sif_pulse_gen #(
    parameter int PERIOD_CYC = sif_pkg::SIF_PULSE_PERIOD_CYC,
    parameter int HIGH_CYC = sif_pkg::SIF_PULSE_HIGH_CYC
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic start, // One-cycle request for a pulse burst.
    input wire logic [7:0] count, // Pulses in the burst.
    output logic led, // LED drive pulse train.
    output logic done // One-cycle end of burst.
);
    import sif_pkg::*;

    localparam int DW = $clog2(PERIOD_CYC);
    localparam logic [DW-1:0] DIV_LAST = DW'(PERIOD_CYC - 1);
    localparam logic [DW-1:0] DIV_HIGH = DW'(HIGH_CYC);

    typedef struct packed {
        logic busy;
        logic [7:0] remain;
        logic [DW-1:0] div;
        logic led;
        logic done;
    } sif_pulse_t;

    sif_pulse_t st_ff;
    sif_pulse_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (!st_ff.busy) begin
            if (start) begin
                nxt_st.div = '0;
                nxt_st.remain = count;
                nxt_st.busy = (count != 8'h00);
                nxt_st.done = (count == 8'h00);
            end
        end else if (st_ff.div == DIV_LAST) begin
            nxt_st.div = '0;
            nxt_st.remain = st_ff.remain - 8'h01;
            if (st_ff.remain == 8'h01) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
        end else begin
            nxt_st.div = st_ff.div + 1'b1;
        end
        nxt_st.led = nxt_st.busy && (nxt_st.div < DIV_HIGH);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign led = st_ff.led;
    assign done = st_ff.done;

endmodule // sif_pulse_gen

`default_nettype wire

// ---- testbench/sif_props.sv ----
`timescale 1ns/10ps
`default_nettype none

module sif_props #(
    parameter int WAIT_STEP_CYC = 4
) (
    input wire logic REF_CLK, // Clock.
    input wire logic RSTN, // Reset, active low.
    input wire logic [7:0] REG_ADDR, // Address.
    input wire logic REG_WR, // Write strobe.
    input wire logic [7:0] REG_WDATA, // Write data.
    input wire logic [7:0] REG_RDATA, // Read data.
    input wire logic PROX_ENABLE, // Proximity on.
    input wire logic LIGHT_IRQ_ENABLE, // Light gate.
    input wire logic PROX_IRQ_ENABLE, // Proximity gate.
    input wire logic [7:0] WAIT_PERIOD_VALUE, // Wait steps.
    input wire logic LIGHT_DONE, // Light result.
    input wire logic PROX_DONE, // Proximity result.
    input wire logic LED_PULSE, // LED train.
    input wire logic WAITING, // Wait state.
    input wire logic [1:0] LED_CURRENT_SEL, // Drive code.
    input wire logic [1:0] PROX_PHOTODIODE_SEL, // Diode code.
    input wire logic [1:0] PROX_GAIN_SEL, // Proximity gain.
    input wire logic [1:0] LIGHT_GAIN_SEL, // Light gain.
    input wire logic LIGHT_IRQ, // Light event.
    input wire logic PROX_IRQ // Proximity event.
);
    logic [7:0] fil_ff, pul_ff, afe_ff;
    logic long_ff;
    logic [8:0] hi_ff;
    int wt_ff;
    int wait_exp;

    // Shadows follow the write port, so no check trusts a readback.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fil_ff <= 8'h00;
            pul_ff <= 8'h00;
            afe_ff <= 8'h00;
            long_ff <= 1'b0;
            hi_ff <= 9'h000;
            wt_ff <= 0;
        end else begin
            if (REG_WR && REG_ADDR == 8'h0c) fil_ff <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h0d) long_ff <= REG_WDATA[1];
            if (REG_WR && REG_ADDR == 8'h0e) pul_ff <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h0f) afe_ff <= REG_WDATA;
            hi_ff <= LED_PULSE ? hi_ff + 9'h001 : 9'h000;
            wt_ff <= WAITING ? wt_ff + 1 : 0;
        end
    end

    assign wait_exp = (256 - int'(WAIT_PERIOD_VALUE)) * WAIT_STEP_CYC
        * (long_ff ? 12 : 1);

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    AST_LIGHT_GATE: assert property (LIGHT_IRQ |->
        $past(LIGHT_IRQ_ENABLE) && $past(LIGHT_DONE))
        else $error("light event without enabled result");
    AST_PROX_GATE: assert property (PROX_IRQ |->
        $past(PROX_IRQ_ENABLE) && $past(PROX_DONE))
        else $error("proximity event without enabled result");
    AST_LIGHT_EVERY: assert property (LIGHT_DONE && LIGHT_IRQ_ENABLE
        && fil_ff[3:0] == 4'h0 |=> LIGHT_IRQ)
        else $error("light code zero missed an event");
    AST_PROX_EVERY: assert property (PROX_DONE && PROX_IRQ_ENABLE
        && fil_ff[7:4] == 4'h0 |=> PROX_IRQ)
        else $error("proximity code zero missed an event");
    AST_LED_WIDTH: assert property ($fell(LED_PULSE) |->
        hi_ff == 9'h0a0)
        else $error("LED pulse width wrong");
    AST_LED_AFTER_LIGHT: assert property (LIGHT_DONE && PROX_ENABLE
        && pul_ff != 8'h00 |-> ##[1:3] LED_PULSE)
        else $error("no burst after light cycle");
    AST_WAIT_LEN: assert property ($fell(WAITING) |->
        wt_ff == wait_exp)
        else $error("wait length wrong");
    AST_AFE_MAP: assert property ({LED_CURRENT_SEL,
        PROX_PHOTODIODE_SEL, PROX_GAIN_SEL, LIGHT_GAIN_SEL} == afe_ff)
        else $error("front end fields differ from register");
    AST_READBACK: assert property ($past(REG_ADDR) == 8'h0e
        && !$past(REG_WR) |-> REG_RDATA == pul_ff)
        else $error("pulse count readback wrong");

    cover property (LIGHT_IRQ);
    cover property (PROX_IRQ);
    cover property ($fell(WAITING));
endmodule // sif_props

bind sif_top sif_props #(.WAIT_STEP_CYC(WAIT_STEP_CYC)) sif_props_inst (
    .REF_CLK, .RSTN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RDATA,
    .PROX_ENABLE, .LIGHT_IRQ_ENABLE, .PROX_IRQ_ENABLE,
    .WAIT_PERIOD_VALUE, .LIGHT_DONE, .PROX_DONE, .LED_PULSE, .WAITING,
    .LED_CURRENT_SEL, .PROX_PHOTODIODE_SEL, .PROX_GAIN_SEL,
    .LIGHT_GAIN_SEL, .LIGHT_IRQ, .PROX_IRQ);

`default_nettype wire

// ---- testbench/sif_afe_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module sif_afe_model (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic light_start, // Light cycle begins.
    input wire logic led, // LED pulse train.
    output logic light_done, // Light result valid.
    output logic prox_done // Proximity result valid.
);
    logic [3:0] lc_ff;
    logic [7:0] gap_ff;

    // The proximity result comes 170 cycles after the LED last fell, past
    // the 160 low cycles that close a burst; the gap counter wraps to idle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lc_ff <= 4'h0;
            gap_ff <= 8'h00;
            light_done <= 1'b0;
            prox_done <= 1'b0;
        end else begin
            lc_ff <= light_start ? 4'h8 : lc_ff - {3'h0, lc_ff != 4'h0};
            light_done <= (lc_ff == 4'h1);
            gap_ff <= led ? 8'h01 : gap_ff + {7'h00, gap_ff != 8'h00};
            prox_done <= (gap_ff == 8'haa);
        end
    end
endmodule // sif_afe_model

`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, run = 1'b0, pen = 1'b0;
    logic wen = 1'b0, lie = 1'b1, pie = 1'b1, led_q = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, afe, r, wpv = 8'hfe;
    logic [15:0] v = 16'h0064;
    logic ls, led, wt, li, pi, ld, pd;
    int fail_count = 0, tests_run = 0, nl = 0, np = 0, nled = 0;
    int wrun = 0, wlen = 0, gl, gp, need, n0;
    int pcs [4] = '{0, 1, 2, 15};
    logic [23:0] rows [6] = '{24'h0ca5_a5, 24'h0dff_02, 24'h0e03_03,
        24'h0fe6_e6, 24'h1055_00, 24'h0b77_00};

    always #25 clk = ~clk;

    sif_top #(.WAIT_STEP_CYC(4)) sif_top_inst (.REF_CLK(clk), .RSTN(rstn),
        .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wd), .REG_RDATA(rd),
        .RUN(run), .PROX_ENABLE(pen), .WAIT_ENABLE(wen),
        .LIGHT_IRQ_ENABLE(lie), .PROX_IRQ_ENABLE(pie),
        .WAIT_PERIOD_VALUE(wpv), .LIGHT_DONE(ld), .LIGHT_CH0(v),
        .LIGHT_LOW_THR(16'h0064), .LIGHT_HIGH_THR(16'h00c8),
        .PROX_DONE(pd), .PROX_DATA(v), .PROX_LOW_THR(16'h0064),
        .PROX_HIGH_THR(16'h00c8), .LIGHT_START(ls), .LED_PULSE(led),
        .WAITING(wt), .LED_CURRENT_SEL(afe[7:6]),
        .PROX_PHOTODIODE_SEL(afe[5:4]), .PROX_GAIN_SEL(afe[3:2]),
        .LIGHT_GAIN_SEL(afe[1:0]), .LIGHT_IRQ(li), .PROX_IRQ(pi));

    sif_afe_model sif_afe_model_inst (.clk(clk), .rst_n(rstn),
        .light_start(ls), .led(led), .light_done(ld), .prox_done(pd));

    always @(posedge clk) begin
        if (li === 1'b1) nl++;
        if (pi === 1'b1) np++;
        if (led === 1'b1 && led_q !== 1'b1) nled++;
        led_q <= led;
        wrun <= (wt === 1'b1) ? wrun + 1 : 0;
        if (wt !== 1'b1 && wrun != 0) wlen <= wrun;
    end

    task automatic chk(input string m, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %0h want %0h", $time, m, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = rd;
    endtask

    // Returns just after a round has been launched.
    task automatic wstart();
        int k = 0;
        @(negedge clk);
        while (ls !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 5000) chk("round start", 0, 1);
    endtask

    task automatic rounds(input int n, input logic [15:0] val,
        output int cl, output int cp);
        int l0, p0;
        @(posedge clk);
        v <= val;
        l0 = nl;
        p0 = np;
        repeat (n) wstart();
        cl = nl - l0;
        cp = np - p0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #4_000_000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 12; a < 16; a++) begin
            rreg(8'(a), r);
            chk("reset value", r, 8'h00);
        end
        foreach (rows[i]) begin
            wreg(rows[i][23:16], rows[i][15:8]);
            rreg(rows[i][23:16], r);
            chk("readback", r, rows[i][7:0]);
        end
        for (int g = 0; g < 4; g++) begin
            wreg(8'h0f, {2'(g), 4'h8, 2'(g)});
            @(negedge clk);
            chk("front end", afe, {2'(g), 4'h8, 2'(g)});
        end
        $display("end test registers");
        @(posedge clk);
        run <= 1'b1;
        wstart();
        for (int c = 0; c < 16; c++) begin
            need = (c == 0) ? 1 : (c < 4) ? c : (c - 3) * 5;
            wreg(8'h0c, 8'(c));
            rounds(1, 16'h0064, gl, gp);
            chk("light in range", gl, c == 0);
            rounds(need - 1, c % 2 ? 16'h0063 : 16'h00c9, gl, gp);
            chk("light early", gl, 0);
            rounds(1, c % 2 ? 16'h0063 : 16'h00c9, gl, gp);
            chk("light fires", gl, 1);
        end
        wreg(8'h0c, 8'h03);
        rounds(1, 16'h0064, gl, gp);
        rounds(2, 16'h00c9, gl, gp);
        rounds(1, 16'h0064, gl, gp);
        rounds(2, 16'h00c9, gl, gp);
        chk("broken run", gl, 0);
        rounds(1, 16'h00c9, gl, gp);
        chk("run fires", gl, 1);
        rounds(2, 16'h00c9, gl, gp);
        chk("no refire", gl, 0);
        wreg(8'h0c, 8'h00);
        lie <= 1'b0;
        rounds(2, 16'h0064, gl, gp);
        chk("light gated", gl, 0);
        lie <= 1'b1;
        $display("end test light filter");
        @(posedge clk);
        pen <= 1'b1;
        foreach (pcs[i]) begin
            need = (pcs[i] == 0) ? 1 : pcs[i];
            wreg(8'h0c, {4'(pcs[i]), 4'h0});
            n0 = nled;
            rounds(1, 16'h00c8, gl, gp);
            chk("prox in range", gp, pcs[i] == 0);
            chk("pulse count", nled - n0, 3);
            rounds(need - 1, 16'h0063, gl, gp);
            chk("prox early", gp, 0);
            rounds(1, 16'h00c9, gl, gp);
            chk("prox fires", gp, 1);
        end
        wreg(8'h0c, 8'h00);
        pie <= 1'b0;
        rounds(2, 16'h0064, gl, gp);
        chk("prox gated", gp, 0);
        pie <= 1'b1;
        $display("end test proximity filter");
        @(posedge clk);
        pen <= 1'b0;
        wen <= 1'b1;
        rounds(2, 16'h0064, gl, gp);
        chk("long wait", wlen, 2 * 4 * 12);
        wreg(8'h0d, 8'h00);
        wpv <= 8'hfd;
        rounds(2, 16'h0064, gl, gp);
        chk("short wait", wlen, 3 * 4);
        $display("end test wait");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rreg(8'h0e, r);
        chk("reset mid run", r, 8'h00);
        $display("end test reset");
        print_verdict();
    end
endmodule // tb

`default_nettype wire
